// File: inc/lasm_pkg.sv
`default_nettype none
package lasm_pkg;
	// register byte addresses (printed offsets not all multiples of four: index times four)
	localparam logic [11:0] IDX_ALARM   = 12'h02c0;
	localparam logic [11:0] IDX_STATUS  = 12'h02c1;
	localparam logic [11:0] IDX_MASK    = 12'h02c2;
	localparam logic [11:0] IDX_LANE    = 12'h02c4;
	localparam logic [13:0] ADDR_ALARM  = {IDX_ALARM, 2'b00};
	localparam logic [13:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
	localparam logic [13:0] ADDR_MASK   = {IDX_MASK, 2'b00};
	localparam logic [13:0] ADDR_LANE   = {IDX_LANE, 2'b00};
	// status and mask field positions
	localparam int BIT_FIFO  = 5;
	localparam int BIT_PLL   = 4;
	localparam int BIT_LINK  = 3;
	localparam int BIT_ALIGN = 2;
	localparam int BIT_RSV1  = 1;
	localparam int BIT_CLK   = 0;
	// reset values
	localparam logic [7:0] RST_STATUS = 8'h3f;
	localparam logic [7:0] RST_MASK   = 8'h3f;
	localparam logic [7:0] RST_LANE   = 8'hff;
	// flag bits that hardware sets and software clears
	localparam logic [7:0] LIVE_BITS  = 8'h3d;
	// link encoding modes
	typedef enum logic [1:0] {
		LASM_ENC_8B10B  = 2'b01,
		LASM_ENC_64B66B = 2'b10
	} lasm_enc_e;
	// condition inputs from the link
	typedef struct packed {
		logic       linkEnable;
		logic       linkIn64b66b;
		logic       linkInDataState;
		logic       linkStartup;
		logic       linkRealign;
		logic       serdesPllLocked;
		logic       sysrefRealign;
		logic       dividerMismatch;
		logic [7:0] laneFifoError;
	} lasm_cond_s;
endpackage : lasm_pkg
`default_nettype wire

// File: rtl/lasm_alarm.sv
// Notes on behaviour
// - lane FIFO error sets status bit five
// - serdes PLL unlock sets status bit four
// - 8b10b: enabled link outside data sets bit three
// - 64b66b: startup or realignment sets bit three
// - sysref clock realignment sets status bit two
// - divider mismatch sets status bit zero
// - all status flags one after reset
// - flags except divider undefined while link disabled
// - set mask bit hides flag from summary
// - lane FIFO error sets per-lane bit
// - per-lane write one clears, persists until cleared or reset
// - clearing FIFO flag clears all lane bits; a lane with a live error stays set
// - per-lane register resets to all ones
// - summary bit is any unmasked set flag
`timescale 1ns/1ps
`default_nettype none
module lasm_alarm (
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	input  wire logic              softReset,
	input  wire lasm_pkg::lasm_cond_s cond,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [13:0]       paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	output logic                   alarmIrq
);
	// ==========================================
	// input synchronisers
	// ==========================================
	// first stage may settle late; only the second stage reads it
	lasm_pkg::lasm_cond_s condMeta_reg;
	// settled copy; the logic reads only this and its delayed copy below
	lasm_pkg::lasm_cond_s condSync_reg;
	// last cycle's settled copy, for edge detection
	lasm_pkg::lasm_cond_s condPrev_reg;

	// no soft reset here: the link conditions are live levels
	// two flops before any logic reads the link conditions
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			condMeta_reg <= '0;
			condSync_reg <= '0;
			condPrev_reg <= '0;
		end else begin
			condMeta_reg <= cond;
			condSync_reg <= condMeta_reg;
			condPrev_reg <= condSync_reg;
		end
	end

	// ==========================================
	// event decode
	// ==========================================
	// set terms, one per status flag
	logic [7:0] statusSet;
	logic       linkStartRise;
	logic       realignRise;
	logic       sysrefRise;
	logic       linkSetLevel;
	logic       linkSetEvent;
	logic       linkSet;
	logic       fifoSet;
	logic       pllSet;
	logic       alignSet;
	logic       clkSet;

	// rising edges of the event inputs; the extra flop holds last cycle
	assign linkStartRise = condSync_reg.linkStartup & ~condPrev_reg.linkStartup;
	assign realignRise   = condSync_reg.linkRealign & ~condPrev_reg.linkRealign;
	assign sysrefRise    = condSync_reg.sysrefRealign & ~condPrev_reg.sysrefRealign;

	// 8b10b: level, enabled link outside the data state
	assign linkSetLevel = condSync_reg.linkEnable & ~condSync_reg.linkInDataState;

	// 64b66b: no data state, so startup and realignment events instead
	assign linkSetEvent = condSync_reg.linkEnable & (linkStartRise | realignRise);

	// mode select for the link flag
	// the mode input is a level, so a switch needs no special care
	assign linkSet = condSync_reg.linkIn64b66b ? linkSetEvent : linkSetLevel;

	// one term per flag; all but the divider mean little while the link is off
	assign fifoSet  = |condSync_reg.laneFifoError;
	assign pllSet   = ~condSync_reg.serdesPllLocked;
	assign alignSet = sysrefRise;
	assign clkSet   = condSync_reg.dividerMismatch;

	// gather the set terms at their status positions
	always_comb begin
		statusSet = 8'h00;
		statusSet[lasm_pkg::BIT_FIFO]  = fifoSet;
		statusSet[lasm_pkg::BIT_PLL]   = pllSet;
		statusSet[lasm_pkg::BIT_LINK]  = linkSet;
		statusSet[lasm_pkg::BIT_ALIGN] = alignSet;
		statusSet[lasm_pkg::BIT_CLK]   = clkSet;
	end

	// ==========================================
	// apb decode
	// ==========================================
	// transfer qualifiers and register hits
	logic       accessPhase;
	logic       wrLane0;
	logic       hitStatus;
	logic       hitMask;
	logic       hitLane;
	logic       hitAlarm;
	logic [7:0] wrByte;

	// taken transfer: access phase with pready already high
	assign accessPhase = psel & penable & pready;
	// only the low byte lane carries register data
	assign wrLane0     = accessPhase & pwrite & pstrb[0];

	// address match, one per register word
	assign hitStatus   = (paddr == lasm_pkg::ADDR_STATUS);
	assign hitMask     = (paddr == lasm_pkg::ADDR_MASK);
	assign hitLane     = (paddr == lasm_pkg::ADDR_LANE);
	assign hitAlarm    = (paddr == lasm_pkg::ADDR_ALARM);

	// register data sits in the low byte of the word
	assign wrByte      = pwdata[7:0];

	// ==========================================
	// registers
	// ==========================================
	// register state and next values
	logic [7:0] alarmStatusFlags_reg;
	logic [7:0] alarmStatusFlags_next;
	logic [7:0] alarmMask_reg;
	logic [7:0] alarmMask_next;
	logic [7:0] laneFifoErrorFlags_reg;
	// per-lane set and clear terms
	logic [7:0] laneSet;
	logic [7:0] laneClear;
	// write decode
	logic [7:0] statusClear;
	logic       fifoFlagClear;
	logic       wrStatus;
	logic       wrMask;
	logic       wrLane;

	// one write strobe per writable register (status, mask, lane), only on the taken access edge
	assign wrStatus = wrLane0 & hitStatus;
	assign wrMask   = wrLane0 & hitMask;
	assign wrLane   = wrLane0 & hitLane;

	// clear pattern; reserved bit one and the top pair ignore written ones
	assign statusClear   = wrStatus ? (wrByte & lasm_pkg::LIVE_BITS) : 8'h00;
	// the flag clear also wipes every lane bit without a live error on the same edge
	assign fifoFlagClear = statusClear[lasm_pkg::BIT_FIFO];

	// next status: ones written clear, a coincident set wins
	always_comb begin
		alarmStatusFlags_next = alarmStatusFlags_reg;
		alarmStatusFlags_next = alarmStatusFlags_next & ~statusClear;
		alarmStatusFlags_next = alarmStatusFlags_next | (statusSet & lasm_pkg::LIVE_BITS);
	end

	// sticky status; soft reset restores the 0x3f reset pattern
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			alarmStatusFlags_reg <= lasm_pkg::RST_STATUS;
		end else if (softReset) begin
			alarmStatusFlags_reg <= lasm_pkg::RST_STATUS;
		end else begin
			alarmStatusFlags_reg <= alarmStatusFlags_next;
		end
	end

	// next mask: whole byte stored as written, reserved bits included
	always_comb begin
		alarmMask_next = alarmMask_reg;
		if (wrMask) begin
			alarmMask_next = wrByte;
		end
	end

	// mask register; a set bit hides its flag from the summary
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			alarmMask_reg <= lasm_pkg::RST_MASK;
		end else if (softReset) begin
			alarmMask_reg <= lasm_pkg::RST_MASK;
		end else begin
			alarmMask_reg <= alarmMask_next;
		end
	end

	// per-lane set and clear terms; a live error beats any clear
	assign laneSet   = condSync_reg.laneFifoError;
	assign laneClear = wrLane ? wrByte : 8'h00;

	// per-lane error bits, one flop per lane
	// priority: live error, then flag clear, then per-lane clear
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : gLane
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					laneFifoErrorFlags_reg[gi] <= lasm_pkg::RST_LANE[gi];
				end else if (softReset) begin
					laneFifoErrorFlags_reg[gi] <= lasm_pkg::RST_LANE[gi];
				end else if (laneSet[gi]) begin
					laneFifoErrorFlags_reg[gi] <= 1'b1;
				end else if (fifoFlagClear) begin
					laneFifoErrorFlags_reg[gi] <= 1'b0;
				end else if (laneClear[gi]) begin
					laneFifoErrorFlags_reg[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ==========================================
	// summary alarm and interrupt
	// ==========================================
	logic summaryAlarm;

	// any flag set and not masked; reserved bits never count
	assign summaryAlarm = |(alarmStatusFlags_reg & ~alarmMask_reg & lasm_pkg::LIVE_BITS);

	// level interrupt, one flop behind the summary so the pin is glitch free
	// reset keeps the pin low; the mask resets to 0x3f, masking every flag, anyway
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			alarmIrq <= 1'b0;
		end else begin
			alarmIrq <= summaryAlarm;
		end
	end

	// ==========================================
	// apb response
	// ==========================================
	// read selection and response next values
	logic [7:0]  readByte;
	logic        unmapped;
	logic        firstAccess;
	logic        pready_next;
	logic [31:0] prdata_next;
	logic        pslverr_next;

	// read mux; summary reads live
	// status reads while the link is off are not meaningful
	always_comb begin
		readByte = 8'h00;
		unmapped = 1'b0;
		if (hitAlarm) begin
			readByte = {7'h00, summaryAlarm};
		end else if (hitStatus) begin
			readByte = alarmStatusFlags_reg;
		end else if (hitMask) begin
			readByte = alarmMask_reg;
		end else if (hitLane) begin
			readByte = laneFifoErrorFlags_reg;
		end else begin
			unmapped = 1'b1;
		end
	end

	// first access cycle: the one wait state before pready
	assign firstAccess = psel & penable & ~pready;

	// response next values; data and error only beside pready
	always_comb begin
		pready_next  = 1'b0;
		prdata_next  = 32'h0000_0000;
		pslverr_next = 1'b0;
		if (firstAccess) begin
			pready_next  = 1'b1;
			pslverr_next = unmapped;
			if (!pwrite) begin
				prdata_next = {24'h00_0000, readByte};
			end
		end
	end

	// response flops: pready is a one-cycle pulse
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= pready_next;
			prdata  <= prdata_next;
			pslverr <= pslverr_next;
		end
	end
endmodule : lasm_alarm
`default_nettype wire

// File: dv/lasm_alarm_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// port checker
module lasm_alarm_chk (
	input wire logic                 clk_sys,
	input wire logic                 reset_n,
	input wire logic                 softReset,
	input wire lasm_pkg::lasm_cond_s cond,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [13:0]          paddr,
	input wire logic [31:0]          pwdata,
	input wire logic                 pready,
	input wire logic [31:0]          prdata,
	input wire logic                 pslverr,
	input wire logic                 alarmIrq
);
	logic [7:0] maskSh;
	logic       mapped;
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// decoded register addresses
	assign mapped = paddr inside {lasm_pkg::ADDR_ALARM, lasm_pkg::ADDR_STATUS, lasm_pkg::ADDR_MASK, lasm_pkg::ADDR_LANE};
	// mask copy from taken writes
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) maskSh <= lasm_pkg::RST_MASK;
		else if (softReset) maskSh <= lasm_pkg::RST_MASK;
		else if (psel && penable && pready && pwrite && paddr == lasm_pkg::ADDR_MASK) maskSh <= pwdata[7:0];
	end
	a_ready_two: assert property (psel && penable && !pready |=> pready) else $error("late pready");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000) else $error("upper bits");
	a_unmapped_err: assert property (pready && !mapped |-> pslverr) else $error("no slave error");
	a_mask_hides: assert property ((maskSh[5:2] == 4'hf && maskSh[0])[*3] |-> !alarmIrq) else $error("masked irq");
	a_pll_irq: assert property ((cond.linkEnable && !cond.serdesPllLocked && !maskSh[4])[*4] |-> ##[0:4] alarmIrq)
		else $error("pll irq missing");
	a_div_irq: assert property ((cond.dividerMismatch && !maskSh[0])[*4] |-> ##[0:4] alarmIrq)
		else $error("divider irq missing");
	a_fifo_irq: assert property ((cond.linkEnable && cond.laneFifoError != 8'h00 && !maskSh[5])[*4] |-> ##[0:4] alarmIrq)
		else $error("fifo irq missing");
	c_irq: cover property ($rose(alarmIrq));
	c_err: cover property (pready && pslverr);
	c_lane: cover property (pready && pwrite && paddr == lasm_pkg::ADDR_LANE);
endmodule : lasm_alarm_chk
bind lasm_alarm lasm_alarm_chk u_lasm_alarm_chk (.clk_sys, .reset_n, .softReset, .cond, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .prdata, .pslverr, .alarmIrq);
`default_nettype wire

// File: dv/lasm_alarm_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// bench top
module lasm_alarm_tb;
	localparam lasm_pkg::lasm_cond_s OK = 16'ha400;
	localparam logic [13:0] ST = lasm_pkg::ADDR_STATUS;
	localparam logic [13:0] MK = lasm_pkg::ADDR_MASK;
	localparam logic [13:0] LN = lasm_pkg::ADDR_LANE;
	localparam logic [13:0] AL = lasm_pkg::ADDR_ALARM;
	localparam logic [7:0]  EXS [7] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01, 8'h08, 8'h08};
	logic                 clk_sys = 1'b0, reset_n = 1'b0, softReset = 1'b0;
	logic                 psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [13:0]          paddr = 14'h0000;
	logic [31:0]          pwdata = 32'h0000_0000, prdata, rdv;
	lasm_pkg::lasm_cond_s cond = OK;
	logic                 pready, pslverr, alarmIrq, lastErr;
	int                   mismatches = 0, checks_done = 0;
	lasm_alarm u_lasm_alarm (.clk_sys, .reset_n, .softReset, .cond, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hf), .pready, .prdata, .pslverr, .alarmIrq);
	// 200 MHz clock
	initial forever #2.5 clk_sys = ~clk_sys;
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : wt
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// one apb transfer, waits for pready
	task automatic apb(input logic w, input logic [13:0] a, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 20);
		if (n >= 20) mismatches++;
		rdv = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	task automatic rdc(input logic [13:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk(rdv, {24'h00_0000, e});
	endtask : rdc
	task automatic complete_run;
		if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task automatic t_reset;
		rdc(ST, 8'h3f);
		rdc(MK, 8'h3f);
		rdc(LN, 8'hff);
		rdc(AL, 8'h00);
	endtask : t_reset
	// each condition sets its flag, zero write ignored, one clears
	task automatic t_events;
		lasm_pkg::lasm_cond_s c;
		apb(1'b1, ST, 8'hff);
		apb(1'b1, LN, 8'hff);
		for (int i = 0; i < 7; i++) begin
			c = OK;
			case (i)
				0: c.laneFifoError = 8'h04;
				1: c.serdesPllLocked = 1'b0;
				2: c.linkInDataState = 1'b0;
				3: c.sysrefRealign = 1'b1;
				4: c.dividerMismatch = 1'b1;
				5: c = 16'hf400;
				6: c = 16'hec00;
				default: ;
			endcase
			cond <= c;
			wt(4);
			cond <= OK;
			wt(4);
			rdc(ST, EXS[i] | 8'h02);
			rdc(LN, c.laneFifoError);
			apb(1'b1, ST, 8'h00);
			rdc(ST, EXS[i] | 8'h02);
			apb(1'b1, ST, EXS[i]);
			rdc(ST, 8'h02);
			rdc(LN, 8'h00);
		end
	endtask : t_events
	task automatic t_irq;
		lasm_pkg::lasm_cond_s c;
		c = OK;
		c.serdesPllLocked = 1'b0;
		c.dividerMismatch = 1'b1;
		c.laneFifoError = 8'h10;
		apb(1'b1, MK, 8'h02);
		chk(32'(alarmIrq), 32'h0000_0000);
		cond <= c;
		wt(6);
		chk(32'(alarmIrq), 32'h0000_0001);
		rdc(AL, 8'h01);
		apb(1'b1, MK, 8'h33);
		wt(1);
		chk(32'(alarmIrq), 32'h0000_0000);
		cond <= OK;
		wt(4);
		apb(1'b1, ST, 8'hff);
		rdc(LN, 8'h00);
	endtask : t_irq
	task automatic t_persist;
		lasm_pkg::lasm_cond_s c;
		c = OK;
		c.laneFifoError = 8'h81;
		cond <= c;
		wt(4);
		apb(1'b1, LN, 8'hff);
		rdc(LN, 8'h81);
		cond <= OK;
		wt(4);
		apb(1'b1, LN, 8'h80);
		rdc(LN, 8'h01);
		apb(1'b1, ST, 8'hff);
	endtask : t_persist
	task automatic t_soft;
		apb(1'b0, 14'h0b0c, 8'h00);
		chk(32'(lastErr), 32'h0000_0001);
		softReset <= 1'b1;
		wt(2);
		softReset <= 1'b0;
		wt(1);
		rdc(ST, 8'h3f);
		rdc(MK, 8'h3f);
		rdc(LN, 8'hff);
	endtask : t_soft
	// main sequence
	initial begin
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		wt(2);
		t_reset;
		t_events;
		t_irq;
		t_persist;
		t_soft;
		complete_run;
	end
	// watchdog
	initial begin
		#50000;
		mismatches++;
		complete_run;
	end
endmodule : lasm_alarm_tb
`default_nettype wire
